// >>> shared/pci_flags_pkg.sv
// constants for the PCI state/control flag block
// assumes all logic runs on the PCI bus clock
package pci_flags_pkg;
    // command register field positions (standard PCI layout)
    localparam int CMD_IO_EN_BIT = 0;
    localparam int CMD_MEM_EN_BIT = 1;
    localparam int CMD_BME_BIT = 2;
    localparam int CMD_PERR_RESP_BIT = 6;
    localparam int CMD_SERR_EN_BIT = 8;
    localparam int CMD_FBB_EN_BIT = 9;
    localparam int CMD_INT_DIS_BIT = 10;
    // writable command bits; the rest read as zero
    localparam logic [15:0] CMD_WR_MASK = 16'h0547;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    // status register field positions (relative to bit 16)
    localparam int STS_INT_BIT = 3;
    localparam int STS_FBB_CAP_BIT = 7;
    localparam int STS_SIG_SERR_BIT = 14;
    localparam int STS_DET_PERR_BIT = 15;
    // write-one-to-clear status bits
    localparam logic [15:0] STS_W1C_MASK = 16'hC000;
    localparam logic [15:0] STS_RESET = 16'h0000;
    // config offset of the command/status dword
    localparam logic [7:0] CFG_CMDSTS_OFFSET = 8'h04;
    // initiator states
    typedef enum logic [1:0] {
        INIT_IDLE = 2'b00,
        INIT_PARKED = 2'b01,
        INIT_ACTIVE = 2'b10
    } init_state_t;
    // target states
    typedef enum logic [1:0] {
        TGT_IDLE = 2'b00,
        TGT_BUSY = 2'b01,
        TGT_DATA = 2'b10,
        TGT_WITHDRAW = 2'b11
    } tgt_state_t;
endpackage

// >>> shared/tgt_state_if.sv
// target state indications passed between target fsm and top
// assumes one clock domain
`timescale 1ns/1ps
interface tgt_state_if;
    logic idle;
    logic busy;
    logic data;
    logic withdraw;
    logic active;
    modport fsm (output idle, output busy, output data, output withdraw, output active);
    modport top (input idle, input busy, input data, input withdraw, input active);
endinterface

// >>> hdl/pci_target_fsm.sv
// target state machine: idle, bus occupied, data transfer, withdrawing
// assumes bus inputs are registered and synchronous to i_sys_clk
`timescale 1ns/1ps
module pci_target_fsm (
    // clock, reset and enable
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // bus and decode
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    input wire logic i_decode_done,
    input wire logic i_hit,
    input wire logic i_target_allowed,
    input wire logic i_term_req,
    // state indications
    tgt_state_if.fsm st
);
    pci_flags_pkg::tgt_state_t state_reg, state_next;
    wire logic bus_end = i_frame_n && i_irdy_n;
    wire logic take = i_hit && i_target_allowed;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pci_flags_pkg::TGT_IDLE: begin
                if (!i_frame_n) state_next = pci_flags_pkg::TGT_BUSY;
            end
            pci_flags_pkg::TGT_BUSY: begin
                if (bus_end) state_next = pci_flags_pkg::TGT_IDLE;
                else if (i_decode_done && take) state_next = pci_flags_pkg::TGT_DATA;
            end
            pci_flags_pkg::TGT_DATA: begin
                if (bus_end) state_next = pci_flags_pkg::TGT_IDLE;
                else if (i_term_req) state_next = pci_flags_pkg::TGT_WITHDRAW;
            end
            pci_flags_pkg::TGT_WITHDRAW: begin
                if (bus_end) state_next = pci_flags_pkg::TGT_IDLE;
            end
            default: state_next = pci_flags_pkg::TGT_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) state_reg <= pci_flags_pkg::TGT_IDLE;
        else if (i_ce) state_reg <= state_next;
    end

    assign st.idle = state_reg == pci_flags_pkg::TGT_IDLE;
    assign st.busy = state_reg == pci_flags_pkg::TGT_BUSY;
    assign st.data = state_reg == pci_flags_pkg::TGT_DATA;
    assign st.withdraw = state_reg == pci_flags_pkg::TGT_WITHDRAW;
    assign st.active = st.data || st.withdraw;

    AST_DATA_NEEDS_HIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && state_reg == pci_flags_pkg::TGT_BUSY && state_next == pci_flags_pkg::TGT_DATA
        |-> take) else $error("target claimed without hit");
    AST_WITHDRAW_HOLDS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        st.withdraw && i_ce && !bus_end |=> st.withdraw) else $error("withdraw left early");
endmodule // pci_target_fsm

// >>> hdl/pci_state_flags.sv
// PCI core state/control flags: initiator idle, target states, error copies,
// interrupt, isolation, command/status register bits.
// assumes bus pins are synchronous to i_sys_clk; config writes arrive as a
// decoded dword write strobe with byte enables.
`timescale 1ns/1ps
module pci_state_flags (
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // pci bus inputs
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    input wire logic i_gnt_n,
    input wire logic i_idsel,
    input wire logic i_parity_error_pin_n,
    input wire logic i_system_error_pin_n,
    // pci bus driven pins
    output logic o_req_n,
    output logic o_inta_n,
    output logic o_inta_oe,
    output logic [31:0] o_ad,
    output logic [3:0] o_cbe,
    output logic o_par,
    output logic o_park_oe,
    // address decode from the core
    input wire logic i_decode_done,
    input wire logic i_bar_hit,
    input wire logic i_cfg_access,
    // config write to command/status dword
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    // status events from the core
    input wire logic i_sig_serr_evt,
    input wire logic i_det_perr_evt,
    // user application
    input wire logic i_request,
    input wire logic i_s_term,
    input wire logic i_c_term,
    input wire logic i_user_interrupt_request_n,
    input wire logic i_internal_bus_isolate,
    input wire logic [31:0] i_user_addr_data_bus,
    // user outputs
    output logic o_initiator_idle,
    output logic o_bus_parked_state,
    output logic o_target_idle,
    output logic o_bus_busy,
    output logic o_target_data,
    output logic o_target_withdraw_state,
    output logic o_parity_error_registered_n,
    output logic o_system_error_registered_n,
    output logic o_user_bus_enable,
    output logic [31:0] o_config_state_bus
);
    pci_flags_pkg::init_state_t init_reg, init_next;
    logic [15:0] cmd_reg, cmd_next;
    logic [15:0] sts_reg, sts_next;
    tgt_state_if tst();

    wire logic bme = cmd_reg[pci_flags_pkg::CMD_BME_BIT];
    wire logic int_dis = cmd_reg[pci_flags_pkg::CMD_INT_DIS_BIT];
    wire logic tgt_allowed = cmd_reg[pci_flags_pkg::CMD_IO_EN_BIT]
        || cmd_reg[pci_flags_pkg::CMD_MEM_EN_BIT];
    wire logic cfg_hit = i_cfg_access && i_idsel;
    wire logic hit = i_bar_hit || cfg_hit;
    // config cycles need no space enable
    wire logic tgt_open = tgt_allowed || cfg_hit;
    wire logic term_req = i_s_term || i_c_term;
    wire logic cmd_sel = i_cfg_wr && i_cfg_addr == pci_flags_pkg::CFG_CMDSTS_OFFSET;
    wire logic granted = !i_gnt_n;
    wire logic bus_free = i_frame_n && i_irdy_n;

    pci_target_fsm u_tgt (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_frame_n(i_frame_n),
        .i_irdy_n(i_irdy_n),
        .i_decode_done(i_decode_done),
        .i_hit(hit),
        .i_target_allowed(tgt_open),
        .i_term_req(term_req),
        .st(tst.fsm)
    );

    // one enable bit fans out to a whole byte lane
    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // byte lanes of the command (lanes 0,1) and status (lanes 2,3) halves
    wire logic [15:0] cmd_lane = lane_mask(i_cfg_be[1:0]);
    wire logic [15:0] sts_lane = lane_mask(i_cfg_be[3:2]);
    wire logic [15:0] sts_evt = {i_det_perr_evt, i_sig_serr_evt, 14'h0000};

    // initiator only goes active with enable, request and grant; grant alone on a free bus parks it
    always_comb begin
        init_next = init_reg;
        case (init_reg)
            pci_flags_pkg::INIT_IDLE: begin
                if (bme && i_request && granted && bus_free) init_next = pci_flags_pkg::INIT_ACTIVE;
                else if (granted && bus_free) init_next = pci_flags_pkg::INIT_PARKED;
            end
            pci_flags_pkg::INIT_PARKED: begin
                if (!granted) init_next = pci_flags_pkg::INIT_IDLE;
                else if (bme && i_request) init_next = pci_flags_pkg::INIT_ACTIVE;
            end
            pci_flags_pkg::INIT_ACTIVE: begin
                if (!bme || !i_request || !granted) init_next = pci_flags_pkg::INIT_IDLE;
            end
            default: init_next = pci_flags_pkg::INIT_IDLE;
        endcase
    end

    // command bits writable only where implemented
    always_comb begin
        cmd_next = cmd_reg;
        if (cmd_sel) begin
            cmd_next = (cmd_reg & ~(cmd_lane & pci_flags_pkg::CMD_WR_MASK))
                | (i_cfg_wdata[15:0] & cmd_lane & pci_flags_pkg::CMD_WR_MASK);
        end
    end

    // events set, write-one clears, set wins
    always_comb begin
        sts_next = sts_reg;
        if (cmd_sel) begin
            sts_next = sts_next & ~(i_cfg_wdata[31:16] & sts_lane & pci_flags_pkg::STS_W1C_MASK);
        end
        sts_next = sts_next | sts_evt;
        sts_next[pci_flags_pkg::STS_INT_BIT] = !i_user_interrupt_request_n;
        sts_next[pci_flags_pkg::STS_FBB_CAP_BIT] = 1'b0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            init_reg <= pci_flags_pkg::INIT_IDLE;
            cmd_reg <= pci_flags_pkg::CMD_RESET;
            sts_reg <= pci_flags_pkg::STS_RESET;
        end else if (i_ce) begin
            init_reg <= init_next;
            cmd_reg <= cmd_next;
            sts_reg <= sts_next;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_req_n <= 1'b1;
            o_initiator_idle <= 1'b1;
            o_bus_parked_state <= 1'b0;
            o_park_oe <= 1'b0;
            o_ad <= 32'h0000_0000;
            o_cbe <= 4'h0;
            o_par <= 1'b0;
        end else if (i_ce) begin
            o_req_n <= !(bme && i_request);
            o_initiator_idle <= init_next == pci_flags_pkg::INIT_IDLE;
            o_bus_parked_state <= init_next == pci_flags_pkg::INIT_PARKED;
            o_park_oe <= init_next == pci_flags_pkg::INIT_PARKED;
            o_ad <= 32'h0000_0000;
            o_cbe <= 4'h0;
            o_par <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_target_idle <= 1'b1;
            o_bus_busy <= 1'b0;
            o_target_data <= 1'b0;
            o_target_withdraw_state <= 1'b0;
            o_parity_error_registered_n <= 1'b1;
            o_system_error_registered_n <= 1'b1;
            o_inta_n <= 1'b1;
            o_inta_oe <= 1'b0;
            o_user_bus_enable <= 1'b0;
            o_config_state_bus <= 32'h0000_0000;
        end else if (i_ce) begin
            o_target_idle <= tst.idle;
            o_bus_busy <= tst.busy;
            o_target_data <= tst.data;
            o_target_withdraw_state <= tst.withdraw;
            o_parity_error_registered_n <= i_parity_error_pin_n;
            o_system_error_registered_n <= i_system_error_pin_n;
            // open-drain interrupt, masked by disable bit
            o_inta_n <= 1'b0;
            o_inta_oe <= !i_user_interrupt_request_n && !int_dis;
            // core releases internal bus while isolated
            o_user_bus_enable <= tst.active && !i_internal_bus_isolate;
            o_config_state_bus <= {sts_next, cmd_next};
        end
    end

    AST_INIT_NO_BME: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !bme |-> init_reg != pci_flags_pkg::INIT_ACTIVE || $past(bme))
        else $error("initiator active without enable");
    AST_REQ_NEEDS_BME: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && !bme ##1 1'b1 |-> o_req_n) else $error("request without enable");
    AST_PERR_COPY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce |=> o_parity_error_registered_n == $past(i_parity_error_pin_n))
        else $error("parity copy wrong");
    AST_SERR_COPY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce |=> o_system_error_registered_n == $past(i_system_error_pin_n))
        else $error("system error copy wrong");
    AST_INT_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && int_dis |=> !o_inta_oe) else $error("interrupt driven while disabled");
    AST_INT_DRIVE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && !int_dis && !i_user_interrupt_request_n |=> o_inta_oe && !o_inta_n)
        else $error("interrupt not driven");
    AST_ONE_HOT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $onehot({o_target_idle, o_bus_busy, o_target_data, o_target_withdraw_state}))
        else $error("target indications not one-hot");
    AST_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && i_det_perr_evt |=> sts_reg[pci_flags_pkg::STS_DET_PERR_BIT])
        else $error("status event lost");
    AST_W1C: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && cmd_sel && i_cfg_be[3] && i_cfg_wdata[31] && !i_det_perr_evt
        |=> !sts_reg[pci_flags_pkg::STS_DET_PERR_BIT]) else $error("w1c failed");
    AST_FBB_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !sts_reg[pci_flags_pkg::STS_FBB_CAP_BIT] && !cmd_reg[pci_flags_pkg::CMD_FBB_EN_BIT])
        else $error("fast back-to-back shown");
    AST_ISOLATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && i_internal_bus_isolate |=> !o_user_bus_enable)
        else $error("bus not isolated");
    AST_NO_RESPOND: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && tst.busy && !tgt_allowed && !(i_cfg_access && i_idsel) |=> !tst.data)
        else $error("responded while disabled");
    AST_IDLE_NO_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && !i_request |=> o_initiator_idle || o_bus_parked_state)
        else $error("initiator busy without request");
    AST_PARK_NEEDS_GRANT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && !granted |=> !o_bus_parked_state && !o_park_oe)
        else $error("parked drive without grant");
    AST_BUSY_ON_FRAME: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && tst.idle && !i_frame_n |=> tst.busy)
        else $error("frame not shown as busy");
    AST_TGT_IDLE_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce |=> o_target_idle == $past(tst.idle))
        else $error("target idle output wrong");
    AST_CMD_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (cmd_reg & ~pci_flags_pkg::CMD_WR_MASK) == 16'h0000)
        else $error("unimplemented command bit set");
    AST_BME_RESET: assert property (@(posedge i_sys_clk)
        !i_rst_b |=> !bme) else $error("enable survived reset");

    COV_TGT_DATA: cover property (@(posedge i_sys_clk) tst.busy ##1 tst.data);
    COV_WITHDRAW: cover property (@(posedge i_sys_clk) tst.data ##1 tst.withdraw);
    COV_PARK: cover property (@(posedge i_sys_clk) o_bus_parked_state);
    COV_INT: cover property (@(posedge i_sys_clk) o_inta_oe);
    COV_ISOLATE: cover property (@(posedge i_sys_clk) i_internal_bus_isolate && tst.active);
endmodule // pci_state_flags

// >>> tb/pci_bus_agent_model.sv
// bus agents and arbiter facing the flag block: frame/irdy, grant, error lines
// assumes the bench pulses i_go for one clock; lines change after rising edges
`timescale 1ns/1ps
module pci_bus_agent_model (
    // clock
    input wire logic i_sys_clk,
    // commands from the bench
    input wire logic i_go,
    input wire logic [3:0] i_len,
    input wire logic i_grant_on,
    input wire logic i_perr,
    input wire logic i_serr,
    // bus lines
    output logic o_frame_n,
    output logic o_irdy_n,
    output logic o_gnt_n,
    output logic o_perr_n,
    output logic o_serr_n
);
    logic [3:0] cnt_reg;
    // released lines sit high: the bus has pull-ups
    initial begin
        o_frame_n = 1'b1;
        o_irdy_n = 1'b1;
        o_gnt_n = 1'b1;
        o_perr_n = 1'b1;
        o_serr_n = 1'b1;
        cnt_reg = 4'h0;
    end
    // frame drops on the last data phase, irdy one clock later
    always @(posedge i_sys_clk) begin
        if (i_go && cnt_reg == 4'h0) begin
            o_frame_n <= 1'b0;
            o_irdy_n <= 1'b0;
            cnt_reg <= i_len;
        end else if (cnt_reg > 4'h1) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (cnt_reg == 4'h1) begin
            o_frame_n <= 1'b1;
            cnt_reg <= 4'h0;
        end else begin
            o_irdy_n <= 1'b1;
        end
        o_gnt_n <= !i_grant_on;
        o_perr_n <= !i_perr;
        o_serr_n <= !i_serr;
    end
endmodule // pci_bus_agent_model

// >>> tb/tb.sv
// self-checking bench for the pci state/control flag block
// assumes the agent model drives the bus side; bench drives at falling edges
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic frame_n, irdy_n, gnt_n, perr_n, serr_n;
    logic idsel = 1'b0, decode_done = 1'b0, bar_hit = 1'b0, cfg_access = 1'b0;
    logic cfg_wr = 1'b0, request = 1'b0, s_term = 1'b0, c_term = 1'b0;
    logic user_interrupt_request_n = 1'b1, isolate = 1'b0, go = 1'b0, grant_on = 1'b0, ce = 1'b1;
    logic perr = 1'b0, serr = 1'b0, serr_evt = 1'b0, perr_evt = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h00000000;
    logic req_n, inta_n, inta_oe, par, park_oe, init_idle, parked, perr_q_n, serr_q_n;
    logic tgt_idle, bus_busy, tgt_data, tgt_wd, bus_en;
    logic [31:0] ad, cfg_bus;
    logic [3:0] cbe;
    int mismatches = 0;
    int checks = 0;
    wire [3:0] tstate = {tgt_idle, bus_busy, tgt_data, tgt_wd};

    always #2.5 sys_clk = ~sys_clk;

    pci_bus_agent_model u_pci_bus_agent_model (.i_sys_clk(sys_clk), .i_go(go),
        .i_len(4'hC), .i_grant_on(grant_on), .i_perr(perr), .i_serr(serr),
        .o_frame_n(frame_n), .o_irdy_n(irdy_n), .o_gnt_n(gnt_n), .o_perr_n(perr_n),
        .o_serr_n(serr_n));

    pci_state_flags u_pci_state_flags (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_gnt_n(gnt_n), .i_idsel(idsel),
        .i_parity_error_pin_n(perr_n), .i_system_error_pin_n(serr_n), .o_req_n(req_n),
        .o_inta_n(inta_n), .o_inta_oe(inta_oe), .o_ad(ad), .o_cbe(cbe), .o_par(par),
        .o_park_oe(park_oe), .i_decode_done(decode_done), .i_bar_hit(bar_hit),
        .i_cfg_access(cfg_access), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
        .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .i_sig_serr_evt(serr_evt),
        .i_det_perr_evt(perr_evt), .i_request(request), .i_s_term(s_term),
        .i_c_term(c_term), .i_user_interrupt_request_n(user_interrupt_request_n),
        .i_internal_bus_isolate(isolate), .i_user_addr_data_bus(32'h00000000),
        .o_initiator_idle(init_idle), .o_bus_parked_state(parked),
        .o_target_idle(tgt_idle), .o_bus_busy(bus_busy), .o_target_data(tgt_data),
        .o_target_withdraw_state(tgt_wd), .o_parity_error_registered_n(perr_q_n),
        .o_system_error_registered_n(serr_q_n), .o_user_bus_enable(bus_en),
        .o_config_state_bus(cfg_bus));

    task automatic end_sim;
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return tgt_idle;
            1: return parked;
            default: return init_idle;
        endcase
    endfunction

    // bounded wait for a state flag to rise
    task automatic wait_hi(input int k, input string name);
        for (int i = 0; i < 40; i++) begin
            if (pick(k) === 1'b1) begin
                return;
            end
            cyc(1);
        end
        chk(name, 32'h1, 32'h0);
        end_sim();
    endtask

    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cyc(1);
        cfg_wr = 1'b0;
        // one idle edge so a following write never re-raises the strobe at once
        cyc(1);
    endtask

    task automatic reset_case;
        chk("config bus", 32'h0, cfg_bus);
        chk("target state", 32'h8, {28'h0, tstate});
        chk("initiator idle", 32'h1, {31'h0, init_idle});
        chk("error copies", 32'h3, {30'h0, perr_q_n, serr_q_n});
    endtask

    task automatic config_case;
        cfg_write(8'h04, 4'h3, 32'h0000FFFF);
        chk("command bits", {16'h0, pci_flags_pkg::CMD_WR_MASK}, {16'h0, cfg_bus[15:0]});
        chk("fast b2b cap", 32'h0, {31'h0, cfg_bus[23]});
        cfg_write(8'h08, 4'hF, 32'h00000000);
        chk("other offset", {16'h0, pci_flags_pkg::CMD_WR_MASK}, {16'h0, cfg_bus[15:0]});
        cfg_write(8'h04, 4'h3, 32'h00000000);
        chk("command cleared", 32'h0, {16'h0, cfg_bus[15:0]});
    endtask

    task automatic tgt_case(input logic [15:0] cmd, input logic cfg, input logic [3:0] exp);
        cfg_write(8'h04, 4'h3, {16'h0, cmd});
        cfg_access = cfg;
        idsel = cfg;
        bar_hit = !cfg;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(2);
        chk("target busy", 32'h4, {28'h0, tstate});
        decode_done = 1'b1;
        cyc(2);
        chk("target decode", {28'h0, exp}, {28'h0, tstate});
        if (exp == 4'h2) begin
            s_term = !cfg;
            c_term = cfg;
            cyc(2);
            chk("target withdraw", 32'h1, {28'h0, tstate});
        end
        wait_hi(0, "target idle");
        chk("target back idle", 32'h8, {28'h0, tstate});
        decode_done = 1'b0;
        bar_hit = 1'b0;
        cfg_access = 1'b0;
        idsel = 1'b0;
        s_term = 1'b0;
        c_term = 1'b0;
    endtask

    task automatic init_case;
        request = 1'b1;
        grant_on = 1'b1;
        cyc(3);
        chk("request without enable", 32'h1, {31'h0, req_n});
        chk("idle or parked", 32'h1, {31'h0, init_idle | parked});
        cfg_write(8'h04, 4'h3, 32'h00000004);
        cyc(2);
        chk("request with enable", 32'h0, {31'h0, req_n});
        chk("initiator active", 32'h0, {31'h0, init_idle});
        request = 1'b0;
        wait_hi(1, "parked");
        chk("park drive", 32'h1, {31'h0, park_oe});
        chk("park address", 32'h0, ad);
        chk("park values", 32'h0, {27'h0, par, cbe});
        grant_on = 1'b0;
        wait_hi(2, "initiator idle");
        chk("request released", 32'h1, {31'h0, req_n});
        cfg_write(8'h04, 4'h3, 32'h00000000);
    endtask

    task automatic err_case(input logic sel);
        perr = !sel;
        serr = sel;
        cyc(2);
        chk("error copies low", {30'h0, sel, !sel}, {30'h0, perr_q_n, serr_q_n});
        perr = 1'b0;
        serr = 1'b0;
        cyc(2);
        chk("error copies high", 32'h3, {30'h0, perr_q_n, serr_q_n});
    endtask

    task automatic intr_case;
        user_interrupt_request_n = 1'b0;
        cyc(1);
        chk("interrupt drive", 32'h1, {31'h0, inta_oe});
        chk("interrupt pin low", 32'h0, {31'h0, inta_n});
        chk("interrupt status", 32'h1, {31'h0, cfg_bus[19]});
        // driver masks then user releases, request held until then
        cfg_write(8'h04, 4'h3, 32'h00000400);
        cyc(1);
        chk("interrupt disabled", 32'h0, {31'h0, inta_oe});
        user_interrupt_request_n = 1'b1;
        cfg_write(8'h04, 4'h3, 32'h00000000);
        cyc(1);
        chk("interrupt released", 32'h0, {31'h0, inta_oe});
        chk("interrupt status off", 32'h0, {31'h0, cfg_bus[19]});
    endtask

    task automatic ce_case;
        ce = 1'b0;
        cfg_write(8'h04, 4'h3, 32'h00000004);
        chk("frozen command", 32'h0, {16'h0, cfg_bus[15:0]});
        ce = 1'b1;
        cyc(1);
        chk("write not taken late", 32'h0, {16'h0, cfg_bus[15:0]});
    endtask

    task automatic mid_reset_case;
        cfg_write(8'h04, 4'h3, 32'h00000004);
        chk("enable before reset", 32'h1, {31'h0, cfg_bus[2]});
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        reset_case();
    endtask

    task automatic status_case(input int b);
        serr_evt = (b == 30);
        perr_evt = (b == 31);
        cyc(1);
        serr_evt = 1'b0;
        perr_evt = 1'b0;
        cyc(1);
        chk("status set", 32'h1, {31'h0, cfg_bus[b]});
        cfg_write(8'h04, 4'hC, 32'h00000000);
        chk("status kept", 32'h1, {31'h0, cfg_bus[b]});
        cfg_write(8'h04, 4'hC, 32'h1 << b);
        chk("status cleared", 32'h0, {31'h0, cfg_bus[b]});
    endtask

    task automatic isolate_case;
        cfg_write(8'h04, 4'h3, 32'h00000002);
        // user retries everything while isolating
        s_term = 1'b1;
        c_term = 1'b1;
        isolate = 1'b1;
        bar_hit = 1'b1;
        decode_done = 1'b1;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(4);
        chk("withdraw isolated", 32'h1, {28'h0, tstate});
        chk("bus enable isolated", 32'h0, {31'h0, bus_en});
        isolate = 1'b0;
        cyc(2);
        chk("bus enable restored", 32'h1, {31'h0, bus_en});
        wait_hi(0, "target idle");
        chk("bus enable idle", 32'h0, {31'h0, bus_en});
        s_term = 1'b0;
        c_term = 1'b0;
        bar_hit = 1'b0;
        decode_done = 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end

    initial begin
        cyc(8);
        rst_b = 1'b1;
        reset_case();
        config_case();
        tgt_case(16'h0002, 1'b0, 4'h2);
        tgt_case(16'h0001, 1'b0, 4'h2);
        tgt_case(16'h0000, 1'b0, 4'h4);
        tgt_case(16'h0000, 1'b1, 4'h2);
        init_case();
        err_case(1'b0);
        err_case(1'b1);
        intr_case();
        ce_case();
        status_case(30);
        status_case(31);
        isolate_case();
        mid_reset_case();
        end_sim();
    end
endmodule // tb
